// ### design/sacrp_port.sv
`timescale 1ns/10ps
`include "sacrp_consts.svh"

// Overview of operation
// - Chip select low enables, high disables
// - Two-channel variant powered off while deselected
// - Two-channel variant powers down between conversions
// - Chip select falling edge starts new transfer
// - Differential variant: first clock enables output
// - Differential variant takes no input word
// - Two null bits precede the result
// - Result MSB first, then zeros forever
// - Eight-bit successive approximation with sample-hold
// - Input bits sampled on rising clock
// - Output bits change on rising clock
// - Leading zeros ignored, first one starts
// - Four input word bits follow start
// - First two word bits select multiplexer
// - Last two bits give acquisition time
// - Input ignored after word until reselect
// - Single-ended to ground, differential between channels
// - Dummy bits are don't-care
// - Hold and convert on fall after dummy
// - Shared wire driven low fifth fall

// ****************************************************************
// Result buffer
// ****************************************************************
module sacrp_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             full;
    logic             empty;

    assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty     = (wr_ptr == rd_ptr);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge ref_clk) begin
        if (in_valid && !full) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr <= '0;
        end else if (in_valid && !full) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_ptr <= '0;
        end else if (out_ready && !empty) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

// ****************************************************************
// Serial command and result port
// ****************************************************************
module sacrp_port (
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    input  wire logic                       two_channel,
    input  wire logic                       cs_n_pin,
    input  wire logic                       sclk_pin,
    input  wire logic                       din_pin,
    output logic                            dout_o,
    output logic                            dout_oe_n,
    input  wire logic [`SACRP_RES_BITS-1:0] analog_input_zero,
    input  wire logic [`SACRP_RES_BITS-1:0] analog_input_one,
    output logic                            converter_powered,
    output sacrp_pkg::sacrp_result_t        result_data,
    output logic                            result_valid,
    input  wire logic                       result_ready
);
    import sacrp_pkg::*;

    logic                       cs_m;
    logic                       cs_s;
    logic                       cs_d;
    logic                       sclk_m;
    logic                       sclk_s;
    logic                       sclk_d;
    logic                       din_m;
    logic                       din_s;
    logic                       rise;
    logic                       fall;
    logic                       cs_fall;

    sacrp_state_t               state;
    logic [`SACRP_CNT_W-1:0]    cnt;
    logic [1:0]                 mux_cfg;
    logic [`SACRP_RES_BITS-1:0] level;
    logic [`SACRP_RES_BITS-1:0] held;
    logic [`SACRP_RES_BITS-1:0] sar;
    logic [`SACRP_RES_BITS-1:0] mask;
    logic [`SACRP_RES_BITS-1:0] trial;
    logic                       sar_bit;
    logic                       acquiring;
    logic                       hold_now;
    logic                       push;
    logic                       space;
    sacrp_result_t              push_data;

    // ****************************************************************
    // Pin synchronisers and edge detect
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            cs_d <= 1'b1;
        end else begin
            cs_m <= cs_n_pin;
            cs_s <= cs_m;
            cs_d <= cs_s;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_m <= 1'b0;
            sclk_s <= 1'b0;
            sclk_d <= 1'b0;
            din_m  <= 1'b0;
            din_s  <= 1'b0;
        end else begin
            sclk_m <= sclk_pin;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            din_m  <= din_pin;
            din_s  <= din_m;
        end
    end

    // Data and clock see the same delay, so the sample stays aligned
    assign rise    = sclk_s && !sclk_d;
    assign fall    = !sclk_s && sclk_d;
    assign cs_fall = !cs_s && cs_d;

    // ****************************************************************
    // Sequence control
    // ****************************************************************
    // Hold only when the buffer can take the result; a full buffer
    // stalls the exchange instead of losing a conversion.
    assign hold_now = (state == SACRP_ACQ) && fall && space;

    always_ff @(posedge ref_clk) begin
        if (rst || cs_s) begin
            state <= SACRP_IDLE;
            cnt   <= '0;
        end else begin
            case (state)
                SACRP_IDLE: begin
                    if (cs_fall) begin
                        state <= two_channel ? SACRP_HUNT : SACRP_ACQ;
                    end
                end
                SACRP_HUNT: begin
                    if (rise && din_s && space) begin
                        state <= SACRP_WORD;
                        cnt   <= '0;
                    end
                end
                SACRP_WORD: begin
                    if (rise) begin
                        cnt <= cnt + 1'b1;
                        if (cnt == `SACRP_WORD_LAST) begin
                            state <= SACRP_ACQ;
                        end
                    end
                end
                SACRP_ACQ: begin
                    if (hold_now) begin
                        state <= SACRP_CONV;
                        cnt   <= '0;
                    end
                end
                SACRP_CONV: begin
                    if (rise) begin
                        cnt <= cnt + 1'b1;
                        if (cnt == `SACRP_LSB_COUNT) begin
                            state <= SACRP_TRAIL;
                        end
                    end
                end
                SACRP_TRAIL: begin
                    state <= SACRP_TRAIL;
                end
                default: begin
                    state <= SACRP_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Input word
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mux_cfg <= '0;
        end else if (state == SACRP_WORD && rise && cnt <= `SACRP_ADDR_LAST) begin
            mux_cfg <= {mux_cfg[0], din_s};
        end
    end

    // ****************************************************************
    // Input selection and sample-hold
    // ****************************************************************
    always_comb begin
        level = '0;
        if (!two_channel) begin
            level = (analog_input_zero >= analog_input_one) ?
                    analog_input_zero - analog_input_one : '0;
        end else begin
            case (mux_cfg)
                `SACRP_MUX_DIFF_01: begin
                    level = (analog_input_zero >= analog_input_one) ?
                            analog_input_zero - analog_input_one : '0;
                end
                `SACRP_MUX_DIFF_10: begin
                    level = (analog_input_one >= analog_input_zero) ?
                            analog_input_one - analog_input_zero : '0;
                end
                `SACRP_MUX_SE_0: begin
                    level = analog_input_zero;
                end
                `SACRP_MUX_SE_1: begin
                    level = analog_input_one;
                end
                default: begin
                    level = '0;
                end
            endcase
        end
    end

    // Tracking starts once the address is in, through the dummy bits
    assign acquiring = (state == SACRP_ACQ) ||
                       (state == SACRP_WORD && cnt > `SACRP_ADDR_LAST);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            held <= '0;
        end else if (acquiring) begin
            held <= level;
        end
    end

    // ****************************************************************
    // Successive approximation
    // ****************************************************************
    assign trial   = sar | mask;
    assign sar_bit = (held >= trial);

    always_ff @(posedge ref_clk) begin
        if (rst || hold_now) begin
            sar  <= '0;
            mask <= `SACRP_MSB_MASK;
        end else if (state == SACRP_CONV && rise && cnt != `SACRP_NULL_LAST) begin
            sar  <= sar_bit ? trial : sar;
            mask <= mask >> 1;
        end
    end

    // ****************************************************************
    // Serial output driver
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst || cs_s) begin
            dout_oe_n <= 1'b1;
        end else if (hold_now) begin
            dout_oe_n <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || cs_s || hold_now) begin
            dout_o <= 1'b0;
        end else if (rise) begin
            if (state == SACRP_CONV && cnt != `SACRP_NULL_LAST) begin
                dout_o <= sar_bit;
            end else begin
                dout_o <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Power control
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            converter_powered <= 1'b0;
        end else if (two_channel) begin
            converter_powered <= !cs_s && (state == SACRP_WORD || state == SACRP_ACQ ||
                                           state == SACRP_CONV);
        end else begin
            converter_powered <= !cs_s;
        end
    end

    // ****************************************************************
    // Result buffer
    // ****************************************************************
    assign push           = (state == SACRP_CONV) && rise && !cs_s && (cnt == `SACRP_LSB_COUNT);
    assign push_data.cfg  = two_channel ? mux_cfg : `SACRP_MUX_DIFF_01;
    assign push_data.code = sar_bit ? trial : sar;

    sacrp_fifo #(
        .WIDTH ($bits(sacrp_result_t)),
        .DEPTH (`SACRP_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_data   (push_data),
        .in_valid  (push),
        .in_ready  (space),
        .out_data  (result_data),
        .out_valid (result_valid),
        .out_ready (result_ready)
    );
endmodule

// ### design/sacrp_consts.svh
`ifndef SACRP_CONSTS_SVH
`define SACRP_CONSTS_SVH

// Result and input word shape
`define SACRP_RES_BITS   8
`define SACRP_WORD_BITS  4
`define SACRP_CNT_W      4
`define SACRP_WORD_LAST  4'h3
`define SACRP_ADDR_LAST  4'h1
`define SACRP_NULL_LAST  4'h0
`define SACRP_LSB_COUNT  4'h8
`define SACRP_MSB_MASK   8'h80
`define SACRP_FIFO_DEPTH 4

// Multiplexer address codes, two-channel variant
`define SACRP_MUX_DIFF_01 2'h0
`define SACRP_MUX_DIFF_10 2'h1
`define SACRP_MUX_SE_0    2'h2
`define SACRP_MUX_SE_1    2'h3

`endif

// ### design/sacrp_pkg.sv
package sacrp_pkg;
`include "sacrp_consts.svh"

    typedef enum logic [2:0] {
        SACRP_IDLE,
        SACRP_HUNT,
        SACRP_WORD,
        SACRP_ACQ,
        SACRP_CONV,
        SACRP_TRAIL
    } sacrp_state_t;

    typedef struct packed {
        logic [1:0]                 cfg;
        logic [`SACRP_RES_BITS-1:0] code;
    } sacrp_result_t;

endpackage

// ### tb/sacrp_port_properties.sv
`timescale 1ns/10ps
// ****
// Port checks
// ****
module sacrp_port_props (
    input wire logic                    ref_clk,
    input wire logic                    rst,
    input wire logic                    two_channel,
    input wire logic                    cs_n_pin,
    input wire logic                    sclk_pin,
    input wire logic                    dout_o,
    input wire logic                    dout_oe_n,
    input wire logic                    converter_powered,
    input wire sacrp_pkg::sacrp_result_t result_data,
    input wire logic                    result_valid,
    input wire logic                    result_ready
);
    import sacrp_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Five cycles covers the pin synchroniser
    oe_released_a: assert property (cs_n_pin [*5] |-> dout_oe_n && !dout_o)
        else $error("output driven while deselected");
    power_deselect_a: assert property (cs_n_pin [*5] |-> !converter_powered)
        else $error("converter powered while deselected");
    dout_on_rise_a: assert property (!dout_oe_n && $past(!dout_oe_n) && $changed(dout_o)
        |-> $past(sclk_pin, 3) && !$past(sclk_pin, 5))
        else $error("output bit changed away from a clock rise");
    oe_on_fall_a: assert property ($fell(dout_oe_n)
        |-> !dout_o && !$past(sclk_pin, 3) && $past(sclk_pin, 6))
        else $error("output enabled away from a clock fall");
    power_on_start_a: assert property (two_channel && $rose(converter_powered)
        |-> !cs_n_pin && $past(sclk_pin, 3))
        else $error("power up without a start bit");
    power_off_end_a: assert property (two_channel && $fell(converter_powered)
        |-> $past(sclk_pin, 4) || $past(cs_n_pin, 2))
        else $error("power down away from last bit or deselect");
    result_hold_a: assert property (result_valid && !result_ready
        |=> result_valid && $stable(result_data))
        else $error("result head lost before pop");
    valid_after_lsb_a: assert property ($rose(result_valid)
        |-> $past(sclk_pin, 3) && !cs_n_pin)
        else $error("result appeared away from last bit");
    cover property ($fell(dout_oe_n) && two_channel);
    cover property ($fell(dout_oe_n) && !two_channel);
    cover property (result_valid && !result_ready ##1 result_valid && result_ready);
endmodule

bind sacrp_port sacrp_port_props u_props (.ref_clk(ref_clk), .rst(rst), .two_channel(two_channel),
    .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .dout_o(dout_o), .dout_oe_n(dout_oe_n),
    .converter_powered(converter_powered), .result_data(result_data), .result_valid(result_valid),
    .result_ready(result_ready));

// ### tb/sacrp_host.sv
`timescale 1ns/10ps
// ****
// Host side of the link
// ****
module sacrp_host (
    input  wire logic ref_clk,
    input  wire logic dout_o,
    input  wire logic dout_oe_n,
    output logic      cs_n,
    output logic      sclk,
    output logic      din
);
    logic last;
    logic line;
    // Released line reads inverted, so a floating bit never matches
    assign line = dout_oe_n ? ~last : dout_o;
    always @(posedge ref_clk) if (!dout_oe_n) last <= dout_o;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
        last = 1'b0;
    end
    // Low half 6 cycles, high half 4: 80 ns keeps under the fastest rate
    task automatic xfer(input logic tc, input logic [1:0] a, input int lead, input int stop,
                        output logic [10:0] cap);
        int n;
        logic [4:0] w;
        n = tc ? lead + 5 : 1;
        w = {1'b1, a, ~a[0], a[1]};
        cap = '0;
        @(posedge ref_clk);
        #1 cs_n = 1'b0;
        for (int i = 0; i < n + 11 && i < stop; i++) begin
            @(posedge ref_clk);
            #1 din = !tc ? ~din : i < lead ? 1'b0 : i < n ? w[4 - (i - lead)] : ~din;
            repeat (5) @(posedge ref_clk);
            #1 if (i >= n) cap = {cap[9:0], line};
            sclk = 1'b1;
            repeat (4) @(posedge ref_clk);
            #1 sclk = 1'b0;
        end
        repeat (2) @(posedge ref_clk);
        #1 cs_n = 1'b1;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule

// ### tb/test_sacrp_port.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", nm, e, g); end end
// ****
// Bench
// ****
module test_sacrp_port;
    import sacrp_pkg::*;
    logic          ref_clk, rst, two_channel, cs_n_pin, sclk_pin, din_pin, result_ready;
    logic          dout_o, dout_oe_n, converter_powered, result_valid, hold_rdy;
    logic [7:0]    an0, an1;
    logic [1:0]    cfg;
    logic [10:0]   cap;
    logic [31:0]   seed, rs;
    sacrp_result_t result_data, exp_r, nxt;
    sacrp_result_t q[$];
    int            error_cnt, checks;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Unipolar: a negative difference reads as zero
    function automatic sacrp_result_t model(input logic [1:0] a);
        logic [7:0] p;
        logic [7:0] m;
        p = a[0] ? an1 : an0;
        m = a[1] ? 8'h00 : a[0] ? an0 : an1;
        return '{cfg: a, code: p > m ? p - m : 8'h00};
    endfunction

    task automatic report_and_stop();
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    sacrp_port uut (.ref_clk(ref_clk), .rst(rst), .two_channel(two_channel), .cs_n_pin(cs_n_pin),
        .sclk_pin(sclk_pin), .din_pin(din_pin), .dout_o(dout_o), .dout_oe_n(dout_oe_n),
        .analog_input_zero(an0), .analog_input_one(an1), .converter_powered(converter_powered),
        .result_data(result_data), .result_valid(result_valid), .result_ready(result_ready));
    sacrp_host host (.ref_clk(ref_clk), .dout_o(dout_o), .dout_oe_n(dout_oe_n), .cs_n(cs_n_pin),
        .sclk(sclk_pin), .din(din_pin));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        rs <= lfsr(rs);
        result_ready <= #1 !hold_rdy && rs[2];
    end

    always @(posedge ref_clk) begin
        if (!rst && result_valid === 1'b1 && result_ready === 1'b1) begin
            exp_r = q.size() != 0 ? q.pop_front() : '1;
            `CHK("result", exp_r, result_data)
        end
    end

    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        two_channel = 1'b1;
        hold_rdy = 1'b1;
        result_ready = 1'b0;
        an0 = 8'h00;
        an1 = 8'h00;
        cfg = 2'h0;
        seed = 32'h2825;
        rs = 32'h2825 ^ 32'h00ff;
        error_cnt = 0;
        checks = 0;
        repeat (4) @(posedge ref_clk);
        #1 rst = 1'b0;
        // Four held results fill the buffer, then random pops drain it
        for (int k = 0; k < 12; k++) begin
            for (int t = 0; t < 40 && !hold_rdy && result_valid === 1'b1; t++) @(posedge ref_clk);
            @(posedge ref_clk);
            #1 seed = lfsr(lfsr(seed));
            two_channel = k % 4 != 3 || k == 7;
            cfg = k[1:0] + k[3:2];
            an0 = k == 5 ? 8'hff : seed[7:0];
            an1 = k == 5 ? 8'h00 : seed[15:8];
            nxt = model(two_channel ? cfg : 2'h0);
            if (k != 7) q.push_back(nxt);
            host.xfer(two_channel, cfg, k % 3, k == 7 ? 3 : 99, cap);
            #1 hold_rdy = k < 3;
            if (k != 7) begin
                `CHK("serial", {2'b00, nxt.code, 1'b0}, cap)
                `CHK("power", 1'b0, converter_powered)
            end
        end
        for (int t = 0; t < 40 && q.size() != 0; t++) @(posedge ref_clk);
        `CHK("drain", 0, q.size())
        report_and_stop();
    end
endmodule
